// ==== pkg/sswirq_pkg.sv ====
// Shared constants, field layouts and carrier types of the supply switch status and
// interrupt block. Assumes a 32-bit AXI4-Lite register bus and one core clock.
package sswirq_pkg;

  // Register indices; a register's byte address is four times its index.
  localparam logic [15:0] SSWIRQ_IDX_CONTROL = 16'h1c00;
  localparam logic [15:0] SSWIRQ_IDX_STATUS  = 16'h1c01;
  localparam logic [15:0] SSWIRQ_IDX_FLAGS   = 16'h1c02;
  localparam logic [15:0] SSWIRQ_IDX_ENABLES = 16'h1c03;
  localparam int          SSWIRQ_IDX_SHIFT   = 2;
  localparam int          SSWIRQ_MIN_ADDR_W  = 16;

  // Field positions of the supply switch status register.
  localparam int SSWIRQ_ST_ALWAYS_ON_GOOD = 5;
  localparam int SSWIRQ_ST_VBUS_GOOD      = 4;
  localparam int SSWIRQ_ST_RAILS_GOOD     = 2;
  localparam int SSWIRQ_ST_ABOVE_ALWAYS   = 1;
  localparam int SSWIRQ_ST_ABOVE_VBUS     = 0;

  // Field positions shared by the event flag and event enable registers.
  localparam int SSWIRQ_EV_TO_VBUS        = 5;
  localparam int SSWIRQ_EV_TO_ALWAYS_ON   = 4;
  localparam int SSWIRQ_EV_ALWAYS_LOST    = 3;
  localparam int SSWIRQ_EV_ALWAYS_ARRIVED = 2;
  localparam int SSWIRQ_EV_VBUS_LOST      = 1;
  localparam int SSWIRQ_EV_VBUS_ARRIVED   = 0;
  localparam int SSWIRQ_EV_W              = 6;

  // Control register field position (force the switch onto the VBUS-derived rail).
  localparam int SSWIRQ_CT_FORCE_VBUS = 0;

  // Reset values.
  localparam logic [SSWIRQ_EV_W-1:0] SSWIRQ_FLAGS_RST   = 6'h00;
  localparam logic [SSWIRQ_EV_W-1:0] SSWIRQ_ENABLES_RST = 6'h00;
  localparam logic                   SSWIRQ_FORCE_RST   = 1'h0;
  // Synchronised pin image at reset: only the rails-good indicator reads one.
  localparam logic [5:0]             SSWIRQ_PINS_RST    = 6'h04;

  // AXI4-Lite response codes.
  localparam logic [1:0] SSWIRQ_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SSWIRQ_RESP_SLVERR = 2'h2;

  // Analog indicators arriving from the supply comparators and the switch sequencer.
  typedef struct packed {
    logic src_on_vbus;
    logic always_on_supply_good;
    logic vbus_supply_good;
    logic rails_good;
    logic switched_rail_above_always_on;
    logic switched_rail_above_vbus;
  } sswirq_supply_s;

  // Register selected by a bus address.
  typedef enum logic [2:0] {
    SSWIRQ_SEL_NONE    = 3'h0,
    SSWIRQ_SEL_CONTROL = 3'h1,
    SSWIRQ_SEL_STATUS  = 3'h3,
    SSWIRQ_SEL_FLAGS   = 3'h2,
    SSWIRQ_SEL_ENABLES = 3'h6
  } sswirq_sel_e;

  // Whole state of the block.
  typedef struct packed {
    sswirq_supply_s              sync1;
    sswirq_supply_s              sync2;
    sswirq_supply_s              prev;
    logic [SSWIRQ_EV_W-1:0]      flags;
    logic [SSWIRQ_EV_W-1:0]      enables;
    logic                        force_vbus;
    logic                        aw_held;
    logic [15:0]                 aw_index;
    logic                        aw_aligned;
    logic                        w_held;
    logic [7:0]                  w_byte0;
    logic                        w_lane0;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
  } sswirq_state_s;

endpackage

// ==== hw/sswirq_top.sv ====
// Supply switch status and event interrupt block with an AXI4-Lite register slave.
// Assumes the supply indicators are asynchronous comparator levels and that the
// switch sequencer obeys the force_vbus_source output.
//
// Functional notes
// RULE1: Status bit 5 shows always-on supply readiness.
// RULE2: Status bit 4 shows VBUS-derived supply readiness.
// RULE3: Status bit 2 shows rails good, resets one.
// RULE4: Status bit 1: switched rail above always-on.
// RULE5: Status bit 0: switched rail above VBUS.
// RULE6: Flag 5 on automatic change to VBUS.
// RULE7: Flag 5 also when force-VBUS bit asserted.
// RULE8: Flag 4 on automatic change to always-on.
// RULE9: Forced VBUS suppresses flag 4 on VBUS loss.
// RULE10: Flag 3 when always-on readiness falls.
// RULE11: Flag 2 when always-on readiness rises.
// RULE12: Flag 1 when VBUS readiness falls.
// RULE13: Flag 0 when VBUS readiness rises.
// RULE14: Flags clear by writing one; reset zero.
// RULE15: Per-event enable bits gate interrupt, reset zero.
// RULE16: Interrupt holds while enabled flag remains set.
// RULE17: Force bit runs switch from VBUS, no auto.
// RULE18: Events request wake without core clock.
// RULE19: Interrupt is OR of flags AND enables.
`timescale 1ns/10ps
`default_nettype none

module sswirq_top
  import sswirq_pkg::*;
#(
  parameter int AXI_ADDR_W = 16
) (
  // Clock and reset.
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write address channel.
  input  wire logic [AXI_ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire logic [AXI_ADDR_W-1:0]     s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Asynchronous supply indicators from the comparators and the switch sequencer.
  input  wire sswirq_pkg::sswirq_supply_s supply_pins,
  // Switch control and interrupt outputs.
  output logic                           force_vbus_source,
  output logic                           irq,
  output logic                           wake_req
);
  import sswirq_pkg::*;

  // The decoder below compares full 16-bit indices, so buses narrower than 16 bits are refused.
  if (AXI_ADDR_W < SSWIRQ_MIN_ADDR_W || AXI_ADDR_W > 32) begin : g_bad_addr_w
    $error("sswirq_top: AXI_ADDR_W must lie between 16 and 32");
  end

  // Maps a word index to the register it names.
  function automatic sswirq_sel_e decode_index(input logic [15:0] idx, input logic aligned);
    sswirq_sel_e sel;
    sel = SSWIRQ_SEL_NONE;
    if (aligned) begin
      unique case (idx)
        SSWIRQ_IDX_CONTROL: sel = SSWIRQ_SEL_CONTROL;
        SSWIRQ_IDX_STATUS:  sel = SSWIRQ_SEL_STATUS;
        SSWIRQ_IDX_FLAGS:   sel = SSWIRQ_SEL_FLAGS;
        SSWIRQ_IDX_ENABLES: sel = SSWIRQ_SEL_ENABLES;
        default:            sel = SSWIRQ_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // Splits a byte address into its word index; upper bits beyond the index must be zero.
  function automatic logic [15:0] addr_index(input logic [AXI_ADDR_W-1:0] addr);
    logic [31:0] wide;
    wide = 32'h0000_0000;
    wide[AXI_ADDR_W-1:0] = addr;
    return wide[SSWIRQ_IDX_SHIFT +: 16];
  endfunction

  // True when the byte address is word aligned and has no bits above the index.
  function automatic logic addr_ok(input logic [AXI_ADDR_W-1:0] addr);
    logic [31:0] wide;
    wide = 32'h0000_0000;
    wide[AXI_ADDR_W-1:0] = addr;
    return (wide[SSWIRQ_IDX_SHIFT-1:0] == 2'h0) && (wide[31:SSWIRQ_IDX_SHIFT+16] == 14'h0000);
  endfunction

  // Assembles the read value of the supply switch status register.
  function automatic logic [31:0] status_word(input sswirq_supply_s s);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[SSWIRQ_ST_ALWAYS_ON_GOOD] = s.always_on_supply_good;          // see RULE1
    v[SSWIRQ_ST_VBUS_GOOD]      = s.vbus_supply_good;               // see RULE2
    v[SSWIRQ_ST_RAILS_GOOD]     = s.rails_good;                     // see RULE3
    v[SSWIRQ_ST_ABOVE_ALWAYS]   = s.switched_rail_above_always_on;  // see RULE4
    v[SSWIRQ_ST_ABOVE_VBUS]     = s.switched_rail_above_vbus;       // see RULE5
    return v;
  endfunction

  sswirq_state_s cur_ff;
  sswirq_state_s nxt_ff;

  // Working values of the next-state process.
  logic [SSWIRQ_EV_W-1:0] ev_set;
  logic [SSWIRQ_EV_W-1:0] ev_clr;
  logic                   ao_rise;
  logic                   ao_fall;
  logic                   vb_rise;
  logic                   vb_fall;
  logic                   src_rise;
  logic                   src_fall;
  logic                   force_rise;
  logic                   do_write;
  sswirq_sel_e            wsel;
  sswirq_sel_e            rsel;
  logic [31:0]            rword;

  // Handshake outputs are combinational from state; one write and one read at a time.
  assign s_axi_awready = !cur_ff.aw_held && !cur_ff.bvalid;
  assign s_axi_wready  = !cur_ff.w_held && !cur_ff.bvalid;
  assign s_axi_arready = !cur_ff.rvalid;
  assign s_axi_bvalid  = cur_ff.bvalid;
  assign s_axi_bresp   = cur_ff.bresp;
  assign s_axi_rvalid  = cur_ff.rvalid;
  assign s_axi_rdata   = cur_ff.rdata;
  assign s_axi_rresp   = cur_ff.rresp;

  // The sequencer reads the force bit directly; it is a flop of the control register.
  assign force_vbus_source = cur_ff.force_vbus;  // see RULE17

  // A single level request: any flag whose enable is set keeps it high until cleared.
  assign irq = |(cur_ff.flags & cur_ff.enables);  // see RULE16 see RULE19

  // The wake request also looks at the raw pins against the settled image, so a supply
  // change asks for wake even while the core clock is stopped. It is glitch-prone by
  // nature and meant only for the power manager's asynchronous wake input.
  always_comb begin
    logic [SSWIRQ_EV_W-1:0] raw_change;
    raw_change = '0;
    raw_change[SSWIRQ_EV_ALWAYS_LOST]    = cur_ff.sync2.always_on_supply_good
                                           && !supply_pins.always_on_supply_good;
    raw_change[SSWIRQ_EV_ALWAYS_ARRIVED] = !cur_ff.sync2.always_on_supply_good
                                           && supply_pins.always_on_supply_good;
    raw_change[SSWIRQ_EV_VBUS_LOST]      = cur_ff.sync2.vbus_supply_good
                                           && !supply_pins.vbus_supply_good;
    raw_change[SSWIRQ_EV_VBUS_ARRIVED]   = !cur_ff.sync2.vbus_supply_good
                                           && supply_pins.vbus_supply_good;
    raw_change[SSWIRQ_EV_TO_VBUS]        = !cur_ff.sync2.src_on_vbus && supply_pins.src_on_vbus;
    raw_change[SSWIRQ_EV_TO_ALWAYS_ON]   = cur_ff.sync2.src_on_vbus && !supply_pins.src_on_vbus;
    wake_req = irq || |(raw_change & cur_ff.enables);  // see RULE18
  end

  // Edges of the settled indicators; the second synchroniser stage against its own past.
  assign ao_rise  = cur_ff.sync2.always_on_supply_good && !cur_ff.prev.always_on_supply_good;
  assign ao_fall  = !cur_ff.sync2.always_on_supply_good && cur_ff.prev.always_on_supply_good;
  assign vb_rise  = cur_ff.sync2.vbus_supply_good && !cur_ff.prev.vbus_supply_good;
  assign vb_fall  = !cur_ff.sync2.vbus_supply_good && cur_ff.prev.vbus_supply_good;
  assign src_rise = cur_ff.sync2.src_on_vbus && !cur_ff.prev.src_on_vbus;
  assign src_fall = !cur_ff.sync2.src_on_vbus && cur_ff.prev.src_on_vbus;

  // A write is performed once both address and data are held and no response is pending.
  assign do_write = cur_ff.aw_held && cur_ff.w_held && !cur_ff.bvalid;
  assign wsel     = decode_index(cur_ff.aw_index, cur_ff.aw_aligned);
  assign rsel     = decode_index(addr_index(s_axi_araddr), addr_ok(s_axi_araddr));

  // Rising force bit: software has just moved the switch onto VBUS.
  assign force_rise = do_write && (wsel == SSWIRQ_SEL_CONTROL) && cur_ff.w_lane0
                      && cur_ff.w_byte0[SSWIRQ_CT_FORCE_VBUS] && !cur_ff.force_vbus;

  // Event vector. Source changes count only when automatic; while the force bit is set the
  // sequencer holds VBUS, so a VBUS loss cannot be reported as a move to always-on.
  always_comb begin
    ev_set = '0;
    ev_set[SSWIRQ_EV_TO_VBUS]        = (src_rise && !cur_ff.force_vbus)  // see RULE6
                                       || force_rise;                    // see RULE7
    ev_set[SSWIRQ_EV_TO_ALWAYS_ON]   = src_fall && !cur_ff.force_vbus;   // see RULE8 see RULE9
    ev_set[SSWIRQ_EV_ALWAYS_LOST]    = ao_fall;                          // see RULE10
    ev_set[SSWIRQ_EV_ALWAYS_ARRIVED] = ao_rise;                          // see RULE11
    ev_set[SSWIRQ_EV_VBUS_LOST]      = vb_fall;                          // see RULE12
    ev_set[SSWIRQ_EV_VBUS_ARRIVED]   = vb_rise;                          // see RULE13
  end

  // Write-one-to-clear mask; only the low byte lane can touch the flags.
  always_comb begin
    ev_clr = '0;
    if (do_write && (wsel == SSWIRQ_SEL_FLAGS) && cur_ff.w_lane0) begin
      ev_clr = cur_ff.w_byte0[SSWIRQ_EV_W-1:0];  // see RULE14
    end
  end

  // Read multiplexer; reserved bits and unmapped addresses read as zero.
  always_comb begin
    rword = 32'h0000_0000;
    unique case (rsel)
      SSWIRQ_SEL_CONTROL: rword[SSWIRQ_CT_FORCE_VBUS] = cur_ff.force_vbus;
      SSWIRQ_SEL_STATUS:  rword = status_word(cur_ff.sync2);
      SSWIRQ_SEL_FLAGS:   rword[SSWIRQ_EV_W-1:0] = cur_ff.flags;
      SSWIRQ_SEL_ENABLES: rword[SSWIRQ_EV_W-1:0] = cur_ff.enables;
      SSWIRQ_SEL_NONE:    rword = 32'h0000_0000;
    endcase
  end

  // Next state of the whole block.
  always_comb begin
    nxt_ff = cur_ff;

    // Two-stage synchroniser on every pin, then the edge-detect history.
    nxt_ff.sync1 = supply_pins;
    nxt_ff.sync2 = cur_ff.sync1;
    nxt_ff.prev  = cur_ff.sync2;

    // A set in the same cycle as its clear wins, so no event is lost.
    nxt_ff.flags = (cur_ff.flags & ~ev_clr) | ev_set;  // see RULE14

    // Write address capture.
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_ff.aw_held    = 1'h1;
      nxt_ff.aw_index   = addr_index(s_axi_awaddr);
      nxt_ff.aw_aligned = addr_ok(s_axi_awaddr);
    end

    // Write data capture; only the low byte carries any field.
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_ff.w_held  = 1'h1;
      nxt_ff.w_byte0 = s_axi_wdata[7:0];
      nxt_ff.w_lane0 = s_axi_wstrb[0];
    end

    // Register update and write response.
    if (do_write) begin
      nxt_ff.aw_held = 1'h0;
      nxt_ff.w_held  = 1'h0;
      nxt_ff.bvalid  = 1'h1;
      nxt_ff.bresp   = SSWIRQ_RESP_OKAY;
      unique case (wsel)
        SSWIRQ_SEL_CONTROL: begin
          if (cur_ff.w_lane0) begin
            nxt_ff.force_vbus = cur_ff.w_byte0[SSWIRQ_CT_FORCE_VBUS];  // see RULE17
          end
        end
        SSWIRQ_SEL_ENABLES: begin
          if (cur_ff.w_lane0) begin
            nxt_ff.enables = cur_ff.w_byte0[SSWIRQ_EV_W-1:0];  // see RULE15
          end
        end
        SSWIRQ_SEL_STATUS, SSWIRQ_SEL_FLAGS: begin
          nxt_ff.bresp = SSWIRQ_RESP_OKAY;
        end
        SSWIRQ_SEL_NONE: begin
          nxt_ff.bresp = SSWIRQ_RESP_SLVERR;
        end
      endcase
    end else if (cur_ff.bvalid && s_axi_bready) begin
      nxt_ff.bvalid = 1'h0;
    end

    // Read: the data is captured at the address handshake and held until taken.
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_ff.rvalid = 1'h1;
      nxt_ff.rdata  = rword;
      nxt_ff.rresp  = (rsel == SSWIRQ_SEL_NONE) ? SSWIRQ_RESP_SLVERR : SSWIRQ_RESP_OKAY;
    end else if (cur_ff.rvalid && s_axi_rready) begin
      nxt_ff.rvalid = 1'h0;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_ff            <= '0;
      cur_ff.sync1      <= SSWIRQ_PINS_RST;
      cur_ff.sync2      <= SSWIRQ_PINS_RST;
      cur_ff.prev       <= SSWIRQ_PINS_RST;
      cur_ff.flags      <= SSWIRQ_FLAGS_RST;    // see RULE14
      cur_ff.enables    <= SSWIRQ_ENABLES_RST;  // see RULE15
      cur_ff.force_vbus <= SSWIRQ_FORCE_RST;
      cur_ff.bresp      <= SSWIRQ_RESP_OKAY;
      cur_ff.rresp      <= SSWIRQ_RESP_OKAY;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // The protection bits carry no meaning for these registers.
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8], s_axi_wstrb[3:1]};

endmodule

`default_nettype wire

// ==== verif/sswirq_checker.sv ====
// Port-level checker for the supply switch status and event interrupt block.
// Assumes it is bound to sswirq_top and that the package is compiled first.
`timescale 1ns/10ps
`default_nettype none

module sswirq_checker
  import sswirq_pkg::*;
#(
  parameter int AXI_ADDR_W = 16
) (
  // Clock and reset.
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Register bus handshakes and payloads.
  input wire logic [AXI_ADDR_W-1:0]      s_axi_awaddr,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic [31:0]                s_axi_wdata,
  input wire logic [3:0]                 s_axi_wstrb,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0]      s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic                       s_axi_rvalid,
  // Supply indicators and block outputs.
  input wire sswirq_pkg::sswirq_supply_s supply_pins,
  input wire logic                       force_vbus_source,
  input wire logic                       irq,
  input wire logic                       wake_req
);
  import sswirq_pkg::*;

  localparam logic [15:0] A_ST = SSWIRQ_IDX_STATUS << SSWIRQ_IDX_SHIFT;
  localparam logic [15:0] A_EN = SSWIRQ_IDX_ENABLES << SSWIRQ_IDX_SHIFT;

  logic [AXI_ADDR_W-1:0] aw_ff;
  logic [AXI_ADDR_W-1:0] ar_ff;
  logic [5:0]            wd_ff;
  logic                  ws_ff;
  logic [5:0]            en_ff;
  sswirq_supply_s        pv_ff;
  logic [2:0]            st_ff;
  logic [31:0]           img;

  // Expected status word for the present pin levels.
  assign img = {26'h0, supply_pins[4:3], 1'b0, supply_pins[2:0]};

  // Shadow of the enables register, rebuilt from completed writes. It lags the real register
  // by the response cycle, so a_irq_masked, alone of the checks that use it, skips cycles with a response pending.
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_ff <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready) ar_ff <= s_axi_araddr;
    if (s_axi_wvalid && s_axi_wready) begin
      wd_ff <= s_axi_wdata[5:0];
      ws_ff <= s_axi_wstrb[0];
    end
    pv_ff <= supply_pins;
    if (!aresetn) begin
      en_ff <= 6'h00;
      st_ff <= 3'h0;
    end else begin
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == SSWIRQ_RESP_OKAY && ws_ff
          && aw_ff == AXI_ADDR_W'(A_EN)) en_ff <= wd_ff;
      // Pins must have settled through the synchroniser before a status read is judged.
      if (supply_pins != pv_ff) st_ff <= 3'h0;
      else if (st_ff != 3'h7) st_ff <= st_ff + 3'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_status_image: assert property (
    $rose(s_axi_rvalid) && ar_ff == AXI_ADDR_W'(A_ST) && st_ff > 3'h3 |-> s_axi_rdata == img)
    else $error("status word does not match the supply pins");
  a_irq_masked: assert property (
    en_ff == 6'h00 && !s_axi_bvalid |-> !irq) else $error("irq high with all enables clear");
  a_irq_holds: assert property (
    $fell(irq) |-> $rose(s_axi_bvalid)) else $error("irq dropped without a register write");
  // Once the pins have passed the synchroniser, the raw wake path adds nothing to irq.
  a_wake_follows_irq: assert property (
    irq || (supply_pins == pv_ff && st_ff > 3'h2) |-> wake_req == irq)
    else $error("wake request differs from irq once the pins have settled");
  a_always_lost_irq: assert property (
    en_ff[3] && $fell(supply_pins.always_on_supply_good) |-> ##[1:4] irq)
    else $error("always-on loss raised no irq");
  a_vbus_arrive_irq: assert property (
    en_ff[0] && $rose(supply_pins.vbus_supply_good) |-> ##[1:4] irq)
    else $error("vbus arrival raised no irq");
  a_force_sets_flag: assert property (
    $rose(force_vbus_source) && en_ff[5] |-> ##[0:1] irq)
    else $error("force bit raised no irq");
  a_force_by_write: assert property (
    $changed(force_vbus_source) |-> $rose(s_axi_bvalid))
    else $error("force output moved without a write");

  c_irq: cover property ($rose(irq));
  c_force: cover property ($rose(force_vbus_source));
  c_status: cover property ($rose(s_axi_rvalid) && ar_ff == AXI_ADDR_W'(A_ST));
endmodule

bind sswirq_top sswirq_checker #(.AXI_ADDR_W(AXI_ADDR_W)) u_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .supply_pins, .force_vbus_source, .irq, .wake_req);

`default_nettype wire

// ==== verif/test_sswirq_top.sv ====
// Self-checking bench for the supply switch status and event interrupt block.
// Assumes the package, the design and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      n_fail++; \
      $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
  end

module test_sswirq_top;
  import sswirq_pkg::*;

  localparam logic [15:0] A_CT = SSWIRQ_IDX_CONTROL << SSWIRQ_IDX_SHIFT;
  localparam logic [15:0] A_ST = SSWIRQ_IDX_STATUS << SSWIRQ_IDX_SHIFT;
  localparam logic [15:0] A_FL = SSWIRQ_IDX_FLAGS << SSWIRQ_IDX_SHIFT;
  localparam logic [15:0] A_EN = SSWIRQ_IDX_ENABLES << SSWIRQ_IDX_SHIFT;
  localparam logic [1:0]  OK   = SSWIRQ_RESP_OKAY;

  logic           aclk = 1'b0;
  logic           aresetn = 1'b0;
  logic [15:0]    s_axi_awaddr = 16'h0000;
  logic [15:0]    s_axi_araddr = 16'h0000;
  logic [2:0]     s_axi_awprot = 3'h0;
  logic [2:0]     s_axi_arprot = 3'h0;
  logic           s_axi_awvalid = 1'b0;
  logic           s_axi_wvalid = 1'b0;
  logic           s_axi_bready = 1'b0;
  logic           s_axi_arvalid = 1'b0;
  logic           s_axi_rready = 1'b0;
  logic [31:0]    s_axi_wdata = 32'h0;
  logic [3:0]     s_axi_wstrb = 4'hf;
  sswirq_supply_s supply_pins = sswirq_supply_s'(6'h04);
  logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]     s_axi_bresp, s_axi_rresp;
  logic [31:0]    s_axi_rdata;
  logic           force_vbus_source, irq, wake_req;
  int             n_fail = 0;
  int             checked = 0;

  // Free-running 200 MHz core clock.
  always #2.5 aclk = ~aclk;

  sswirq_top #(.AXI_ADDR_W(16)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_pins,
    .force_vbus_source, .irq, .wake_req);

  // One write; address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        `CHK("bresp", er, s_axi_bresp)
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  // One read, compared with the expected word and response.
  task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        `CHK("rdata", ed, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // Move the pins, let the synchroniser settle, check status, flags and irq, then show
  // that writing zeros keeps a flag and writing ones clears it.
  task automatic ev(input logic [5:0] p, input logic [5:0] st, input logic [5:0] fl,
                    input logic ei);
    @(posedge aclk);
    supply_pins <= sswirq_supply_s'(p);
    repeat (6) @(posedge aclk);
    rd(A_ST, {26'h0, st}, OK);
    rd(A_FL, {26'h0, fl}, OK);
    `CHK("irq", ei, irq)
    wr(A_FL, {26'h3ffffff, ~fl}, OK);
    rd(A_FL, {26'h0, fl}, OK);
    wr(A_FL, {26'h0, fl}, OK);
    rd(A_FL, 32'h0, OK);
    `CHK("irq", 1'b0, irq)
  endtask

  task automatic complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_ST, 32'h04, OK);
    rd(A_FL, 32'h00, OK);
    rd(A_EN, 32'h00, OK);
    rd(A_CT, 32'h00, OK);
    ev(6'h0c, 6'h14, 6'h01, 1'b0);
    // A pending flag only reaches irq through its own enable bit.
    @(posedge aclk);
    supply_pins <= sswirq_supply_s'(6'h04);
    repeat (6) @(posedge aclk);
    wr(A_EN, 32'h3d, OK);
    `CHK("irq", 1'b0, irq)
    wr(A_EN, 32'h02, OK);
    `CHK("irq", 1'b1, irq)
    `CHK("wake_req", 1'b1, wake_req)
    wr(A_FL, 32'h02, OK);
    `CHK("irq", 1'b0, irq)
    wr(A_EN, 32'hffffffff, OK);
    rd(A_EN, 32'h3f, OK);
    // A raw supply change asks for wake before the synchroniser lets a flag through.
    @(posedge aclk);
    supply_pins <= sswirq_supply_s'(6'h14);
    @(posedge aclk);
    `CHK("wake_req", 1'b1, wake_req)
    `CHK("irq", 1'b0, irq)
    ev(6'h17, 6'h27, 6'h04, 1'b1);
    ev(6'h1c, 6'h34, 6'h01, 1'b1);
    ev(6'h14, 6'h24, 6'h02, 1'b1);
    ev(6'h04, 6'h04, 6'h08, 1'b1);
    ev(6'h24, 6'h04, 6'h20, 1'b1);
    ev(6'h04, 6'h04, 6'h10, 1'b1);
    // Forcing the source raises the to-VBUS event and silences automatic changes.
    wr(A_CT, 32'h01, OK);
    `CHK("force", 1'b1, force_vbus_source)
    rd(A_FL, 32'h20, OK);
    wr(A_FL, 32'h20, OK);
    ev(6'h1c, 6'h34, 6'h05, 1'b1);
    ev(6'h34, 6'h24, 6'h02, 1'b1);
    ev(6'h14, 6'h24, 6'h00, 1'b0);
    wr(A_CT, 32'h00, OK);
    `CHK("force", 1'b0, force_vbus_source)
    // Unmapped space and the read-only status register.
    rd(16'h7010, 32'h0, SSWIRQ_RESP_SLVERR);
    wr(16'h7010, 32'hff, SSWIRQ_RESP_SLVERR);
    wr(A_ST, 32'h3f, OK);
    rd(A_ST, 32'h24, OK);
    complete_run;
  end

  // Watchdog: the sequence needs a few thousand cycles at most.
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    complete_run;
  end
endmodule

`default_nettype wire
